// ### sec_material_pkg.sv
/*
 * Constants for the frame security material loader: register indexes, frame
 * control field positions, frame types, nonce layout, cipher operations and states.
 * Assumes a 32-bit Avalon-MM slave where each register is one aligned word.
 */
// Notes on behaviour
// - Receive decrypt or authentication ending in error raises the tag-failure flag.
// - Stored receive length counts every baseband octet including tag, never status octets.
// - Status octets sit after the tag; software reads them at length plus one.
// - Receive decrypts the tag first, since it uses the initial counter.
// - Transmit size error when length with tag and CRC is zero or too big.
// - Frame-format error flag when the buffered frame cannot be parsed.
// - MAC security applies exactly when the frame's security-enable bit is one.
// - Network-layer security is processed before MAC-layer security.
// - Two-bit frame version picks 2003 or 2006 style material retrieval.
// - Beacons get no automatic material retrieval; key lookup stays with software.
// - 2006 nonce: 8-octet source, 4-octet counter, five zeros plus level.
// - Short source addresses spoil the nonce; beacons spoil the payload index.
// - MAC security header index is the first MAC header octet.
// - Payload index: first payload octet, second for commands, software for beacons.
// - MAC indexes are buffer offsets, 0 length, 1 first control octet.
// - Network indexes count from MAC payload; device loads them for proprietary frames.
// - Autofill disable in transmit stops writes of all three index fields.
// - Seven-bit end index marks last secured payload octet; tag follows it.
// - Transmit nonce source address comes from own extended address registers.
// - 2003 nonce: 8-octet source, 4-octet counter, 1-octet key sequence counter.
// - Receive processing runs only on the decrypt trigger, cleared on completion.
package sec_material_pkg;
  // ********************************************************************
  // Register indexes; the byte address is four times the index.
  // ********************************************************************
  localparam logic [6:0] idx_mac_cfg = 7'h10;
  localparam logic [6:0] idx_suite_cfg = 7'h11;
  localparam logic [6:0] idx_header = 7'h2b;
  localparam logic [6:0] idx_payload = 7'h2c;
  localparam logic [6:0] idx_end = 7'h2d;
  localparam logic [6:0] idx_nonce_first = 7'h50;
  localparam logic [6:0] idx_nonce_last = 7'h5c;
  localparam logic [6:0] idx_control = 7'h60;
  localparam logic [6:0] idx_status = 7'h61;
  localparam logic [6:0] idx_rx_length = 7'h62;
  localparam logic [6:0] idx_ext_first = 7'h68;
  localparam logic [6:0] idx_ext_last = 7'h6f;
  // Field positions.
  localparam int fmt_bit = 1;
  localparam int ctl_disable_tx_material_autofill_bit = 0;
  localparam int ctl_tx_send_trigger_bit = 1;
  localparam int ctl_rx_decrypt_trigger_bit = 2;
  localparam int st_tag_fail_bit = 0;
  localparam int st_dec_done_bit = 1;
  localparam int st_size_err_bit = 2;
  localparam int st_fmt_err_bit = 3;
  localparam int st_tx_done_bit = 4;
  localparam int fc_sec_en_bit = 3;
  localparam int fc_ver_lsb = 12;
  localparam int fc_sam_lsb = 14;
  // Frame control encodings.
  localparam logic [2:0] type_beacon = 3'h0;
  localparam logic [2:0] type_data = 3'h1;
  localparam logic [2:0] type_command = 3'h3;
  localparam logic [2:0] type_stream = 3'h5;
  localparam logic [1:0] ver_2003 = 2'h0;
  localparam logic [1:0] sam_extended = 2'h3;
  // Buffer layout and nonce.
  localparam logic [6:0] mhr_first_offset = 7'h01;
  localparam int nonce_octets = 13;
  localparam logic [7:0] reset_byte = 8'h00;
  // Cipher operations.
  localparam logic [1:0] op_tx = 2'h0;
  localparam logic [1:0] op_tag = 2'h1;
  localparam logic [1:0] op_msg = 2'h2;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_load = 3'b001,
    st_tag = 3'b010,
    st_msg = 3'b011,
    st_txc = 3'b100,
    st_send = 3'b101
  } seq_e;
endpackage

// ### frame_security_material_loader.sv
/*
 * Security material loader: derives header, payload and end indexes and the
 * CCM nonce, sequences the external cipher and raises size, format and tag
 * flags. Assumes an outside parser presents decoded frame fields as stable
 * synchronous levels while a trigger is pending, and an outside AES engine.
 */
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
module frame_security_material_loader #(
  parameter int max_frame_octets = 127,
  parameter int crc_octets = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [8:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Parsed frame fields
  input wire logic [15:0] frame_control,
  input wire logic [2:0] security_level_field,
  input wire logic [31:0] frame_counter,
  input wire logic [7:0] key_sequence_counter,
  input wire logic [63:0] frame_source_address,
  input wire logic [6:0] mac_payload_offset,
  input wire logic [6:0] nwk_header_offset,
  input wire logic [6:0] nwk_payload_offset,
  input wire logic [6:0] tx_frame_length,
  input wire logic frame_parse_error,
  // Baseband receive report
  input wire logic rx_frame_end,
  input wire logic [6:0] rx_octet_count,
  // Cipher engine
  output logic cipher_start,
  output logic [1:0] cipher_op,
  input wire logic cipher_done,
  input wire logic cipher_fail,
  // Transmitter
  output logic tx_send_start,
  input wire logic tx_sent,
  // Status octet location
  output logic [7:0] rx_status_address
);

  // ********************************************************************
  // Parameter checks.
  // ********************************************************************
  if (max_frame_octets < 1 || max_frame_octets > 127) begin : g_bad_max
    $error("max_frame_octets must lie in 1 to 127");
  end
  if (crc_octets < 0 || crc_octets > 4) begin : g_bad_crc
    $error("crc_octets must lie in 0 to 4");
  end

  localparam logic [7:0] max_len = 8'(max_frame_octets);
  localparam logic [7:0] crc_len = 8'(crc_octets);

  // ********************************************************************
  // State.
  // ********************************************************************
  sec_material_pkg::seq_e seq_r;
  logic [7:0] mac_cfg_r;
  logic [3:0] suite_r;
  logic [6:0] header_index_r;
  logic [6:0] payload_index_r;
  logic [6:0] end_index_r;
  logic [7:0] nonce_r [sec_material_pkg::nonce_octets];
  logic [7:0] ext_addr_r [8];
  logic disable_tx_material_autofill_r;
  logic tx_send_trigger_r;
  logic rx_decrypt_trigger_r;
  logic rx_tag_fail_flag_r;
  logic rx_decrypt_done_flag_r;
  logic tx_size_error_flag_r;
  logic frame_format_error_flag_r;
  logic tx_done_flag_r;
  logic [6:0] rx_length_r;
  logic ack_r;
  logic cipher_start_r;
  logic [1:0] cipher_op_r;
  logic tx_send_start_r;
  logic dir_rx_r;

  // ********************************************************************
  // Frame decode.
  // ********************************************************************
  logic [2:0] frame_type;
  logic sec_en;
  logic ver_2003;
  logic beacon;
  logic proprietary;
  logic [7:0] mic_len;
  logic [7:0] tx_total;
  logic size_bad;
  logic autofill;
  logic [6:0] frame_len;

  assign frame_type = frame_control[2:0];
  assign sec_en = frame_control[sec_material_pkg::fc_sec_en_bit];
  assign ver_2003 = frame_control[sec_material_pkg::fc_ver_lsb +: 2] == sec_material_pkg::ver_2003;
  assign beacon = frame_type == sec_material_pkg::type_beacon;
  assign proprietary = mac_cfg_r[sec_material_pkg::fmt_bit];

  // Tag size: 2006 frames carry the level, 2003 frames use the global suite.
  always_comb begin
    mic_len = 8'h00;
    if (sec_en && !ver_2003) begin
      case (security_level_field[1:0])
        2'h1: mic_len = 8'h04;
        2'h2: mic_len = 8'h08;
        2'h3: mic_len = 8'h10;
        default: mic_len = 8'h00;
      endcase
    end else if (sec_en) begin
      case (suite_r)
        4'h5, 4'hf: mic_len = 8'h04;
        4'h6, 4'he: mic_len = 8'h08;
        4'h7, 4'hd: mic_len = 8'h10;
        default: mic_len = 8'h00;
      endcase
    end
  end

  assign frame_len = dir_rx_r ? rx_length_r : tx_frame_length;
  assign tx_total = {1'b0, tx_frame_length} + mic_len;
  assign size_bad = (tx_total == 8'h00) || (tx_total > max_len);
  // Transmit with the disable bit set leaves every piece of material to software.
  assign autofill = !(disable_tx_material_autofill_r && !dir_rx_r);

  // ********************************************************************
  // Avalon-MM slave: one wait cycle, then registered read data.
  // ********************************************************************
  logic req;
  logic [6:0] idx;
  logic wr_en;
  assign req = read || write;
  assign idx = address[8:2];
  assign waitrequest = req && !ack_r;
  // A write lands at the edge where waitrequest is seen low, as the master expects.
  assign wr_en = write && ack_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (idx >= sec_material_pkg::idx_nonce_first && idx <= sec_material_pkg::idx_nonce_last) begin
      rd_byte = nonce_r[4'(idx - sec_material_pkg::idx_nonce_first)];
    end else if (idx >= sec_material_pkg::idx_ext_first && idx <= sec_material_pkg::idx_ext_last) begin
      rd_byte = ext_addr_r[3'(idx - sec_material_pkg::idx_ext_first)];
    end else begin
      case (idx)
        sec_material_pkg::idx_mac_cfg: rd_byte = mac_cfg_r;
        sec_material_pkg::idx_suite_cfg: rd_byte = {4'h0, suite_r};
        // Bit seven of each index is reserved and reads as zero.
        sec_material_pkg::idx_header: rd_byte = {1'b0, header_index_r};
        sec_material_pkg::idx_payload: rd_byte = {1'b0, payload_index_r};
        sec_material_pkg::idx_end: rd_byte = {1'b0, end_index_r};
        sec_material_pkg::idx_control: rd_byte = {5'h00, rx_decrypt_trigger_r, tx_send_trigger_r, disable_tx_material_autofill_r};
        sec_material_pkg::idx_status: rd_byte = {3'h0, tx_done_flag_r, frame_format_error_flag_r,
                                                 tx_size_error_flag_r, rx_decrypt_done_flag_r, rx_tag_fail_flag_r};
        sec_material_pkg::idx_rx_length: rd_byte = {1'b0, rx_length_r};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_r) begin
      readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ********************************************************************
  // Configuration registers.
  // ********************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mac_cfg_r <= sec_material_pkg::reset_byte;
      suite_r <= 4'h0;
      disable_tx_material_autofill_r <= 1'b0;
    end else if (wr_en) begin
      if (idx == sec_material_pkg::idx_mac_cfg) begin
        mac_cfg_r <= writedata[7:0];
      end
      if (idx == sec_material_pkg::idx_suite_cfg) begin
        suite_r <= writedata[3:0];
      end
      if (idx == sec_material_pkg::idx_control) begin
        disable_tx_material_autofill_r <= writedata[sec_material_pkg::ctl_disable_tx_material_autofill_bit];
      end
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_ext
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        ext_addr_r[i] <= sec_material_pkg::reset_byte;
      end else if (wr_en && idx == sec_material_pkg::idx_ext_first + 7'(i)) begin
        ext_addr_r[i] <= writedata[7:0];
      end
    end
  end

  // ********************************************************************
  // Sequencer.
  // ********************************************************************
  logic loading;
  logic seq_end;
  assign loading = seq_r == sec_material_pkg::st_load;
  assign seq_end = (seq_r == sec_material_pkg::st_msg && cipher_done)
                   || (seq_r == sec_material_pkg::st_send && tx_sent);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_r <= sec_material_pkg::st_idle;
      dir_rx_r <= 1'b0;
      cipher_start_r <= 1'b0;
      cipher_op_r <= sec_material_pkg::op_tx;
      tx_send_start_r <= 1'b0;
    end else begin
      cipher_start_r <= 1'b0;
      tx_send_start_r <= 1'b0;
      case (seq_r)
        sec_material_pkg::st_idle: begin
          // A pending receive trigger is served before a transmit one.
          if (rx_decrypt_trigger_r) begin
            dir_rx_r <= 1'b1;
            seq_r <= sec_material_pkg::st_load;
          end else if (tx_send_trigger_r) begin
            dir_rx_r <= 1'b0;
            seq_r <= sec_material_pkg::st_load;
          end
        end
        sec_material_pkg::st_load: begin
          // Material lands this cycle; the cipher is started only afterwards.
          if (frame_parse_error || (!dir_rx_r && size_bad)) begin
            seq_r <= sec_material_pkg::st_idle;
          end else if (dir_rx_r) begin
            cipher_start_r <= 1'b1;
            cipher_op_r <= sec_material_pkg::op_tag;
            seq_r <= sec_material_pkg::st_tag;
          end else if (sec_en) begin
            cipher_start_r <= 1'b1;
            cipher_op_r <= sec_material_pkg::op_tx;
            seq_r <= sec_material_pkg::st_txc;
          end else begin
            tx_send_start_r <= 1'b1;
            seq_r <= sec_material_pkg::st_send;
          end
        end
        sec_material_pkg::st_tag: begin
          if (cipher_done && cipher_fail) begin
            seq_r <= sec_material_pkg::st_idle;
          end else if (cipher_done) begin
            cipher_start_r <= 1'b1;
            cipher_op_r <= sec_material_pkg::op_msg;
            seq_r <= sec_material_pkg::st_msg;
          end
        end
        sec_material_pkg::st_msg: begin
          if (cipher_done) begin
            seq_r <= sec_material_pkg::st_idle;
          end
        end
        sec_material_pkg::st_txc: begin
          if (cipher_done) begin
            tx_send_start_r <= 1'b1;
            seq_r <= sec_material_pkg::st_send;
          end
        end
        sec_material_pkg::st_send: begin
          if (tx_sent) begin
            seq_r <= sec_material_pkg::st_idle;
          end
        end
        default: seq_r <= sec_material_pkg::st_idle;
      endcase
    end
  end

  assign cipher_start = cipher_start_r;
  assign cipher_op = cipher_op_r;
  assign tx_send_start = tx_send_start_r;

  // ********************************************************************
  // Triggers: software sets, hardware clears when the pass ends.
  // ********************************************************************
  logic rx_finish;
  logic tx_finish;
  assign rx_finish = dir_rx_r && (seq_end || (loading && frame_parse_error)
                     || (seq_r == sec_material_pkg::st_tag && cipher_done && cipher_fail));
  assign tx_finish = !dir_rx_r && (seq_end || (loading && (frame_parse_error || size_bad)));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_decrypt_trigger_r <= 1'b0;
      tx_send_trigger_r <= 1'b0;
    end else begin
      // One layer per trigger: network-layer material goes while fmt_bit of
      // mac_cfg_r is set, MAC-layer material while software keeps it clear.
      if (wr_en && idx == sec_material_pkg::idx_control && writedata[sec_material_pkg::ctl_rx_decrypt_trigger_bit]) begin
        rx_decrypt_trigger_r <= 1'b1;
      end else if (rx_finish) begin
        rx_decrypt_trigger_r <= 1'b0;
      end
      if (wr_en && idx == sec_material_pkg::idx_control && writedata[sec_material_pkg::ctl_tx_send_trigger_bit]) begin
        tx_send_trigger_r <= 1'b1;
      end else if (tx_finish) begin
        tx_send_trigger_r <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Event flags: write one to clear, a simultaneous set wins.
  // ********************************************************************
  logic clr_st;
  logic tag_fail_ev;
  logic dec_done_ev;
  assign clr_st = wr_en && idx == sec_material_pkg::idx_status;
  assign tag_fail_ev = dir_rx_r && cipher_done && cipher_fail
                       && (seq_r == sec_material_pkg::st_tag || seq_r == sec_material_pkg::st_msg);
  assign dec_done_ev = dir_rx_r && seq_r == sec_material_pkg::st_msg && cipher_done && !cipher_fail;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_tag_fail_flag_r <= 1'b0;
      rx_decrypt_done_flag_r <= 1'b0;
      tx_size_error_flag_r <= 1'b0;
      frame_format_error_flag_r <= 1'b0;
      tx_done_flag_r <= 1'b0;
    end else begin
      rx_tag_fail_flag_r <= tag_fail_ev
        || (rx_tag_fail_flag_r && !(clr_st && writedata[sec_material_pkg::st_tag_fail_bit]));
      rx_decrypt_done_flag_r <= dec_done_ev
        || (rx_decrypt_done_flag_r && !(clr_st && writedata[sec_material_pkg::st_dec_done_bit]));
      tx_size_error_flag_r <= (loading && !dir_rx_r && size_bad)
        || (tx_size_error_flag_r && !(clr_st && writedata[sec_material_pkg::st_size_err_bit]));
      frame_format_error_flag_r <= (loading && frame_parse_error)
        || (frame_format_error_flag_r && !(clr_st && writedata[sec_material_pkg::st_fmt_err_bit]));
      tx_done_flag_r <= (!dir_rx_r && seq_r == sec_material_pkg::st_send && tx_sent)
        || (tx_done_flag_r && !(clr_st && writedata[sec_material_pkg::st_tx_done_bit]));
    end
  end

  // ********************************************************************
  // Receive length and status octet location.
  // ********************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_length_r <= 7'h00;
    end else if (rx_frame_end) begin
      rx_length_r <= rx_octet_count;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_status_address <= 8'h00;
    end else begin
      rx_status_address <= {1'b0, rx_length_r} + 8'h01;
    end
  end

  // ********************************************************************
  // Index autofill.
  // ********************************************************************
  logic idx_fill;
  logic [7:0] end_calc;
  assign idx_fill = loading && autofill && sec_en && !beacon;
  // Last secured octet: before the CRC, and on receive also before the tag.
  assign end_calc = {1'b0, frame_len} - crc_len - (dir_rx_r ? mic_len : 8'h00);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      header_index_r <= 7'h00;
      payload_index_r <= 7'h00;
      end_index_r <= 7'h00;
    end else if (idx_fill) begin
      if (proprietary) begin
        header_index_r <= nwk_header_offset;
        payload_index_r <= nwk_payload_offset;
      end else begin
        header_index_r <= sec_material_pkg::mhr_first_offset;
        if (frame_type == sec_material_pkg::type_command) begin
          payload_index_r <= mac_payload_offset + 7'h01;
        end else if (frame_type == sec_material_pkg::type_data || frame_type == sec_material_pkg::type_stream) begin
          payload_index_r <= mac_payload_offset;
        end
      end
      end_index_r <= end_calc[6:0];
    end else if (wr_en) begin
      if (idx == sec_material_pkg::idx_header) begin
        header_index_r <= writedata[6:0];
      end
      if (idx == sec_material_pkg::idx_payload) begin
        payload_index_r <= writedata[6:0];
      end
      if (idx == sec_material_pkg::idx_end) begin
        end_index_r <= writedata[6:0];
      end
    end
  end

  // ********************************************************************
  // Nonce autofill.
  // ********************************************************************
  logic nonce_fill;
  logic [63:0] src_addr;
  // On receive a short source address cannot be expanded, so the nonce is
  // left for the host to write before it sets the decrypt trigger.
  assign nonce_fill = idx_fill && !proprietary
                      && (!dir_rx_r || frame_control[sec_material_pkg::fc_sam_lsb +: 2] == sec_material_pkg::sam_extended);
  assign src_addr = dir_rx_r ? frame_source_address
                    : {ext_addr_r[7], ext_addr_r[6], ext_addr_r[5], ext_addr_r[4],
                       ext_addr_r[3], ext_addr_r[2], ext_addr_r[1], ext_addr_r[0]};

  for (genvar i = 0; i < sec_material_pkg::nonce_octets; i++) begin : g_nonce
    logic [7:0] fill_byte;
    always_comb begin
      fill_byte = 8'h00;
      if (ver_2003) begin
        if (i < 8) begin
          fill_byte = src_addr[8 * (i % 8) +: 8];
        end else if (i < 12) begin
          fill_byte = frame_counter[8 * (i % 4) +: 8];
        end else begin
          fill_byte = key_sequence_counter;
        end
      end else begin
        if (i < 8) begin
          fill_byte = src_addr[8 * (7 - (i % 8)) +: 8];
        end else if (i < 12) begin
          fill_byte = frame_counter[8 * (3 - (i % 4)) +: 8];
        end else begin
          fill_byte = {5'b00000, security_level_field};
        end
      end
    end
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        nonce_r[i] <= sec_material_pkg::reset_byte;
      end else if (nonce_fill) begin
        nonce_r[i] <= fill_byte;
      end else if (wr_en && idx == sec_material_pkg::idx_nonce_first + 7'(i)) begin
        nonce_r[i] <= writedata[7:0];
      end
    end
  end

endmodule // frame_security_material_loader

// ### fsml_monitor.sv
/* Checker for the loader ports; assumes the bench plays cipher and transmitter. */
`timescale 1ns/10ps
module fsml_mon (
  input wire logic clock, rst_n, read, write, waitrequest, frame_parse_error,
  input wire logic rx_frame_end, cipher_start, cipher_done, cipher_fail, tx_send_start,
  input wire logic [8:0] address,
  input wire logic [31:0] writedata, readdata,
  input wire logic [15:0] frame_control,
  input wire logic [6:0] tx_frame_length, rx_octet_count,
  input wire logic [1:0] cipher_op,
  input wire logic [7:0] rx_status_address
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence ctl_wr;
    write && !waitrequest && address == 9'h180;
  endsequence
  sequence rx_go;
    ctl_wr and (writedata[2] && !frame_parse_error);
  endsequence
  sequence tx_plain;
    ctl_wr and (writedata[2:1] == 2'h1 && !frame_control[3] && !frame_parse_error);
  endsequence
  AST_RX_ORDER: assert property (rx_go |-> !cipher_start [*3] ##1 cipher_start && cipher_op == 2'h1)
    else $error("tag op did not start after load");
  AST_TAG_FIRST: assert property (cipher_start && cipher_op == 2'h2 |-> $past(cipher_op) == 2'h1 && $past(cipher_done))
    else $error("message op ran before tag op");
  AST_FAIL_STOP: assert property (cipher_done && cipher_fail |=> !cipher_start [*3])
    else $error("cipher restarted after failure");
  AST_STATUS_ADDR: assert property (rx_frame_end |-> ##2 rx_status_address == {1'b0, $past(rx_octet_count, 2)} + 8'h01)
    else $error("status octet address wrong");
  AST_RSV_BIT: assert property (read && !waitrequest && address[8:2] inside {7'h2b, 7'h2c, 7'h2d} |-> readdata[31:7] == 25'h0)
    else $error("index top bit not zero");
  AST_PARSE: assert property (frame_parse_error && $past(frame_parse_error) |-> !cipher_start && !tx_send_start)
    else $error("work started on unparsable frame");
  AST_SIZE: assert property (tx_plain and (tx_frame_length == 7'h00) |=> !(cipher_start || tx_send_start) [*6])
    else $error("empty frame was sent");
  AST_TX_PLAIN: assert property (tx_plain and (tx_frame_length != 7'h00) |-> !cipher_start throughout ##[1:6] tx_send_start)
    else $error("plain frame not sent directly");
endmodule // fsml_mon
bind frame_security_material_loader fsml_mon mon (.clock, .rst_n, .read, .write, .waitrequest, .frame_parse_error,
  .rx_frame_end, .cipher_start, .cipher_done, .cipher_fail, .tx_send_start, .address, .writedata, .readdata,
  .frame_control, .tx_frame_length, .rx_octet_count, .cipher_op, .rx_status_address);

// ### frame_security_material_loader_tb.sv
/* Bench for the loader; it plays host, parser, cipher engine and transmitter. */
`timescale 1ns/10ps
module frame_security_material_loader_tb;
  logic clock = 0, rst_n = 0, read = 0, write = 0, frame_parse_error = 0, rx_frame_end = 0;
  logic cipher_done = 0, cipher_fail = 0, tx_sent = 0, fail_mode = 0, waitrequest, cipher_start, tx_send_start;
  logic [8:0] address = 0;
  logic [31:0] writedata = 0, readdata, frame_counter = 32'hd1c2b3a4;
  logic [15:0] frame_control = 0;
  logic [63:0] frame_source_address = 64'h8877665544332211;
  logic [7:0] key_sequence_counter = 8'h5a, rx_status_address, rd;
  logic [6:0] mac_payload_offset = 7'h0a, nwk_header_offset = 7'h03, nwk_payload_offset = 7'h05;
  logic [6:0] tx_frame_length = 0, rx_octet_count = 0;
  logic [2:0] security_level_field = 3'h5;
  logic [1:0] cipher_op;
  logic [3:0] ops = 0;
  int n_fail = 0, comparisons = 0;
  always #12.5 clock = ~clock;
  frame_security_material_loader dut (.clock, .rst_n, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .frame_control, .security_level_field, .frame_counter, .key_sequence_counter,
    .frame_source_address, .mac_payload_offset, .nwk_header_offset, .nwk_payload_offset,
    .tx_frame_length, .frame_parse_error, .rx_frame_end, .rx_octet_count, .cipher_start,
    .cipher_op, .cipher_done, .cipher_fail, .tx_send_start, .tx_sent, .rx_status_address);
  always @(posedge clock) begin
    cipher_done <= cipher_start;
    cipher_fail <= cipher_start & fail_mode;
    tx_sent <= tx_send_start;
    if (cipher_start) ops <= {ops[1:0], cipher_op};
  end
  task automatic acc(input logic [6:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= {idx, 2'b00};
    writedata <= {24'h0, wd};
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [6:0] idx, input logic [7:0] exp);
    acc(idx, 1'b0, 8'h00);
    chk(rd, exp);
  endtask
  // Clears the flags, fires a trigger and polls until hardware drops it.
  task automatic go(input logic [7:0] trig);
    acc(7'h61, 1'b1, 8'hff);
    acc(7'h60, 1'b1, trig);
    do acc(7'h60, 1'b0, 8'h00); while (rd[2:1] != 2'h0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #300us;
    n_fail++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    for (int k = 0; k < 3; k++) rdchk(7'h2b + 7'(k), 8'h00);
    rdchk(7'h7f, 8'h00);
    acc(7'h2c, 1'b1, 8'h7f);
    rdchk(7'h2c, 8'h7f);
    $display("register test done");
    frame_control <= 16'hd009;
    rx_octet_count <= 7'h20;
    rx_frame_end <= 1'b1;
    @(posedge clock);
    rx_frame_end <= 1'b0;
    repeat (2) @(posedge clock);
    chk(rx_status_address, 8'h21);
    go(8'h04);
    chk({4'h0, ops}, 8'h06);
    rdchk(7'h61, 8'h02);
    rdchk(7'h2b, 8'h01);
    rdchk(7'h2c, 8'h0a);
    rdchk(7'h2d, 8'h1a);
    rdchk(7'h50, 8'h88);
    rdchk(7'h58, 8'hd1);
    rdchk(7'h5c, 8'h05);
    $display("receive 2006 test done");
    frame_control <= 16'hc009;
    fail_mode <= 1'b1;
    go(8'h04);
    rdchk(7'h61, 8'h01);
    rdchk(7'h50, 8'h11);
    rdchk(7'h58, 8'ha4);
    rdchk(7'h5c, 8'h5a);
    fail_mode <= 1'b0;
    acc(7'h2b, 1'b1, 8'h33);
    frame_control <= 16'hd008;
    go(8'h04);
    rdchk(7'h2b, 8'h33);
    frame_control <= 16'hd009;
    tx_frame_length <= 7'h10;
    go(8'h03);
    rdchk(7'h2b, 8'h33);
    for (int k = 0; k < 8; k++) acc(7'h68 + 7'(k), 1'b1, 8'h40 + 8'(k));
    go(8'h02);
    rdchk(7'h50, 8'h47);
    frame_control <= 16'h9009;
    acc(7'h50, 1'b1, 8'h77);
    go(8'h04);
    rdchk(7'h50, 8'h77);
    frame_control <= 16'h0001;
    go(8'h02);
    rdchk(7'h61, 8'h10);
    tx_frame_length <= 7'h00;
    go(8'h02);
    rdchk(7'h61, 8'h04);
    frame_parse_error <= 1'b1;
    go(8'h04);
    rdchk(7'h61, 8'h08);
    $display("error test done");
    give_verdict();
  end
endmodule // frame_security_material_loader_tb
